/* File: hub_enable_ctrl.sv */
`timescale 1ns/1ps
module hub_enable_ctrl
(
	input  wire logic                                  CLK,
	input  wire logic                                  ARST_N,
	input  wire logic                                  LINK_CLK,
	input  wire logic                                  EN_REQ_VALID,
	input  wire logic [hub_ctrl_pkg::SW_PORTS-1:0]     EN_REQ_MASK,
	output      logic                                  EN_REQ_READY,
	output      logic                                  EN_DONE,
	output      logic [hub_ctrl_pkg::SW_PORTS-1:0]     EN_STATE,
	output      logic                                  BUS_IDLE,
	input  wire logic [hub_ctrl_pkg::SW_PORTS-1:0]     PORT_EN_I,
	output      logic [hub_ctrl_pkg::SW_PORTS-1:0]     PORT_EN_O,
	output      logic [hub_ctrl_pkg::SW_PORTS-1:0]     PORT_EN_OE,
	input  wire logic [hub_ctrl_pkg::ALL_PORTS-1:0]    SDA_I,
	input  wire logic [hub_ctrl_pkg::ALL_PORTS-1:0]    SCL_I,
	input  wire logic                                  DATA_FIRST_LOW_LINE_I,
	input  wire logic                                  DATA_HELD_LOW_LINE_I,
	input  wire logic                                  CLOCK_FIRST_LOW_LINE_I,
	input  wire logic                                  CLOCK_HELD_LOW_LINE_I
);

	localparam int NP  = hub_ctrl_pkg::SW_PORTS;
	localparam int NA  = hub_ctrl_pkg::ALL_PORTS;
	localparam int PW  = NP + 2 * NA + 4;
	localparam int CW  = $clog2(hub_ctrl_pkg::IDLE_CYC + 1);
	localparam logic [CW-1:0] IDLE_LAST   =
		CW'(hub_ctrl_pkg::IDLE_CYC - 1);
	localparam logic [CW-1:0] SETTLE_LAST =
		CW'(hub_ctrl_pkg::SETTLE_CYC - 1);

	initial
	begin
		if (hub_ctrl_pkg::SETTLE_CYC > hub_ctrl_pkg::IDLE_CYC)
			$error("hub_enable_ctrl: settle longer than idle window");
	end

	////////////////////////////////////////////////////////////////////////
	// reset release, one copy per domain
	logic rst_s1_reg;
	logic rst_n_reg;
	logic lrst_s1_reg;
	logic lrst_n_reg;

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			rst_s1_reg <= 1'b0;
			rst_n_reg  <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_n_reg  <= rst_s1_reg;
		end
	end

	always_ff @(posedge LINK_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			lrst_s1_reg <= 1'b0;
			lrst_n_reg  <= 1'b0;
		end
		else
		begin
			lrst_s1_reg <= 1'b1;
			lrst_n_reg  <= lrst_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers on the link clock
	logic [PW-1:0] pin_s1_reg;
	logic [PW-1:0] pin_s2_reg;
	wire  [PW-1:0] pin_raw;

	// any-low view per line; hub soft low reads low here too
	assign pin_raw = {PORT_EN_I, SDA_I, SCL_I,
		DATA_FIRST_LOW_LINE_I, DATA_HELD_LOW_LINE_I,
		CLOCK_FIRST_LOW_LINE_I, CLOCK_HELD_LOW_LINE_I};

	always_ff @(posedge LINK_CLK or negedge lrst_n_reg)
	begin
		if (!lrst_n_reg)
		begin
			pin_s1_reg <= '1;
			pin_s2_reg <= '1;
		end
		else
		begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
		end
	end

	wire [NP-1:0] en_pins = pin_s2_reg[PW-1 -: NP];
	wire [NA-1:0] sda_s   = pin_s2_reg[2*NA+3 -: NA];
	wire [NA-1:0] scl_s   = pin_s2_reg[NA+3 -: NA];
	wire [3:0]    exp_s   = pin_s2_reg[3:0];

	////////////////////////////////////////////////////////////////////////
	// idle decision
	hub_ctrl_pkg::link_state_t state_reg;
	logic [NP-1:0]             mask_reg;
	logic [NP-1:0]             en_oe_reg;
	logic [NP-1:0]             en_o_reg;
	logic [CW-1:0]             cnt_reg;
	logic                      bus_idle_reg;
	logic                      done_load_reg;
	logic [NP-1:0]             done_word_reg;
	wire                       req_strobe;
	wire  [NP-1:0]             req_mask;
	wire                       done_busy;
	wire  [NP-1:0]             port_quiet;
	wire  [NP-1:0]             changing;
	wire                       shared_quiet;
	wire                       idle_now;

	// expansion lines all high: no hub sees a low anywhere
	assign shared_quiet = &exp_s;

	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++)
		begin : g_port
			// port gi+1; port 0 is never switched
			assign port_quiet[gi] = sda_s[gi+1] & scl_s[gi+1];
		end
	endgenerate

	function automatic logic bus_idle_ok(input logic [NP-1:0] quiet,
		input logic [NP-1:0] chg);
		bus_idle_ok = &(quiet | ~chg);
	endfunction

	assign changing = mask_reg ^ ~en_oe_reg;
	assign idle_now = shared_quiet && bus_idle_ok(port_quiet, changing);

	always_ff @(posedge LINK_CLK or negedge lrst_n_reg)
	begin
		if (!lrst_n_reg)
		begin
			state_reg     <= hub_ctrl_pkg::LINK_IDLE;
			mask_reg      <= '1;
			en_oe_reg     <= hub_ctrl_pkg::EN_OE_RESET;
			en_o_reg      <= '0;
			cnt_reg       <= '0;
			bus_idle_reg  <= 1'b0;
			done_load_reg <= 1'b0;
			done_word_reg <= '0;
		end
		else
		begin
			bus_idle_reg  <= shared_quiet;
			done_load_reg <= 1'b0;
			unique case (state_reg)
				hub_ctrl_pkg::LINK_IDLE:
				begin
					cnt_reg <= '0;
					if (req_strobe)
					begin
						mask_reg  <= req_mask;
						state_reg <= hub_ctrl_pkg::LINK_WAIT;
					end
				end
				hub_ctrl_pkg::LINK_WAIT:
				begin
					// a low on the expansion lines or on a port being switched restarts the quiet window
					if (!idle_now)
						cnt_reg <= '0;
					else if (cnt_reg == IDLE_LAST)
					begin
						// low pulls the pin, high releases it to pull-up
						en_oe_reg <= ~mask_reg;
						cnt_reg   <= '0;
						state_reg <= hub_ctrl_pkg::LINK_REPORT;
					end
					else
						cnt_reg <= cnt_reg + 1'b1;
				end
				hub_ctrl_pkg::LINK_REPORT:
				begin
					if (cnt_reg != SETTLE_LAST)
						cnt_reg <= cnt_reg + 1'b1;
					else if (!done_busy && !done_load_reg)
					begin
						// wired level: a sub-controller may hold it low
						done_word_reg <= en_pins;
						done_load_reg <= 1'b1;
						state_reg     <= hub_ctrl_pkg::LINK_IDLE;
					end
				end
			endcase
		end
	end

	assign PORT_EN_OE = en_oe_reg;
	assign PORT_EN_O  = en_o_reg;

	////////////////////////////////////////////////////////////////////////
	// crossings between CLK and LINK_CLK
	logic          load_reg;
	logic          pending_reg;
	logic          ready_reg;
	logic          done_reg;
	logic [NP-1:0] state_out_reg;
	logic          idle_s1_reg;
	logic          idle_s2_reg;
	logic [NP-1:0] req_word_reg;
	wire           req_busy;
	wire           done_strobe;
	wire  [NP-1:0] done_word;
	wire           accept = EN_REQ_VALID && ready_reg;

	word_crossing #(.WIDTH(NP)) u_req
	(
		.src_clk    (CLK),
		.src_rst_n  (rst_n_reg),
		.src_load   (load_reg),
		.src_word   (req_word_reg),
		.src_busy   (req_busy),
		.dst_clk    (LINK_CLK),
		.dst_rst_n  (lrst_n_reg),
		.dst_strobe (req_strobe),
		.dst_word   (req_mask)
	);

	word_crossing #(.WIDTH(NP)) u_done
	(
		.src_clk    (LINK_CLK),
		.src_rst_n  (lrst_n_reg),
		.src_load   (done_load_reg),
		.src_word   (done_word_reg),
		.src_busy   (done_busy),
		.dst_clk    (CLK),
		.dst_rst_n  (rst_n_reg),
		.dst_strobe (done_strobe),
		.dst_word   (done_word)
	);

	// one request in flight; a second would race the idle window
	always_ff @(posedge CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			load_reg      <= 1'b0;
			req_word_reg  <= '1;
			pending_reg   <= 1'b0;
			ready_reg     <= 1'b0;
			done_reg      <= 1'b0;
			state_out_reg <= '1;
			idle_s1_reg   <= 1'b0;
			idle_s2_reg   <= 1'b0;
		end
		else
		begin
			load_reg    <= accept;
			if (accept)
				req_word_reg <= EN_REQ_MASK;
			pending_reg <= (pending_reg || accept) && !done_strobe;
			ready_reg   <= !pending_reg && !accept && !load_reg &&
				!req_busy && !done_strobe;
			done_reg    <= done_strobe;
			if (done_strobe)
				state_out_reg <= done_word;
			idle_s1_reg <= bus_idle_reg;
			idle_s2_reg <= idle_s1_reg;
		end
	end

	assign EN_REQ_READY = ready_reg;
	assign EN_DONE      = done_reg;
	assign EN_STATE     = state_out_reg;
	assign BUS_IDLE     = idle_s2_reg;

endmodule // hub_enable_ctrl

/* File: hub_ctrl_pkg.sv */
package hub_ctrl_pkg;

	// switchable ports of the hub; port 0 has no enable
	localparam int SW_PORTS   = 4;
	localparam int ALL_PORTS  = 5;

	// link clock as the bench makes it
	localparam int LINK_PERIOD_PS = 12000;

	// both the shared bus and the local port must stay quiet this long
	localparam int IDLE_TIME_NS = 1000;
	localparam int IDLE_CYC =
		(IDLE_TIME_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;

	// enable pins are re-read after this many link cycles
	localparam int SETTLE_CYC = 4;

	// enable pins released at reset: the pull-up enables every port
	localparam logic [SW_PORTS-1:0] EN_OE_RESET = 4'h0;

	typedef enum logic [1:0]
	{
		LINK_IDLE   = 2'b00,
		LINK_WAIT   = 2'b01,
		LINK_REPORT = 2'b11
	} link_state_t;

endpackage

/* File: word_crossing.sv */
`timescale 1ns/1ps
module word_crossing
#(
	parameter int WIDTH = 4
)
(
	input  wire logic             src_clk,
	input  wire logic             src_rst_n,
	input  wire logic             src_load,
	input  wire logic [WIDTH-1:0] src_word,
	output      logic             src_busy,
	input  wire logic             dst_clk,
	input  wire logic             dst_rst_n,
	output      logic             dst_strobe,
	output      logic [WIDTH-1:0] dst_word
);

	initial
	begin
		if (WIDTH < 1)
			$error("word_crossing: WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] data_reg;
	logic             req_reg;
	logic             ack_s1_reg;
	logic             ack_s2_reg;
	logic             req_s1_reg;
	logic             req_s2_reg;
	logic             req_s3_reg;
	logic             strobe_reg;
	logic [WIDTH-1:0] word_reg;
	wire              take;
	wire              arrived;

	////////////////////////////////////////////////////////////////////////
	// source side: data held still while the toggle is in flight
	assign src_busy = req_reg ^ ack_s2_reg;
	assign take     = src_load && !src_busy;

	always_ff @(posedge src_clk or negedge src_rst_n)
	begin
		if (!src_rst_n)
		begin
			data_reg   <= '0;
			req_reg    <= 1'b0;
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
		end
		else
		begin
			if (take)
			begin
				data_reg <= src_word;
				req_reg  <= ~req_reg;
			end
			ack_s1_reg <= req_s3_reg;
			ack_s2_reg <= ack_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// destination side: edge seen between second and third flop only
	assign arrived = req_s2_reg ^ req_s3_reg;

	always_ff @(posedge dst_clk or negedge dst_rst_n)
	begin
		if (!dst_rst_n)
		begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			req_s3_reg <= 1'b0;
			strobe_reg <= 1'b0;
			word_reg   <= '0;
		end
		else
		begin
			req_s1_reg <= req_reg;
			req_s2_reg <= req_s1_reg;
			req_s3_reg <= req_s2_reg;
			strobe_reg <= arrived;
			if (arrived)
				word_reg <= data_reg;
		end
	end

	assign dst_strobe = strobe_reg;
	assign dst_word   = word_reg;

endmodule // word_crossing

/* File: hub_enable_chk.sv */
`timescale 1ns/1ps
module hub_enable_chk
(
	input  wire logic       CLK,
	input  wire logic       ARST_N,
	input  wire logic       LINK_CLK,
	input  wire logic       EN_REQ_VALID,
	input  wire logic       EN_REQ_READY,
	input  wire logic       EN_DONE,
	input  wire logic [3:0] EN_STATE,
	input  wire logic       BUS_IDLE,
	input  wire logic [3:0] PORT_EN_I,
	input  wire logic [3:0] PORT_EN_O,
	input  wire logic [3:0] PORT_EN_OE,
	input  wire logic       DATA_FIRST_LOW_LINE_I,
	input  wire logic       DATA_HELD_LOW_LINE_I,
	input  wire logic       CLOCK_FIRST_LOW_LINE_I,
	input  wire logic       CLOCK_HELD_LOW_LINE_I
);
	logic       lines_high;
	logic [7:0] quiet_reg;
	logic [7:0] quiet_next;
	assign lines_high = DATA_FIRST_LOW_LINE_I & DATA_HELD_LOW_LINE_I
		& CLOCK_FIRST_LOW_LINE_I & CLOCK_HELD_LOW_LINE_I;
	// saturates so a long quiet spell never wraps back to zero
	assign quiet_next = !lines_high ? 8'h00
		: (quiet_reg == 8'hFF ? quiet_reg : quiet_reg + 8'h01);
	always_ff @(posedge LINK_CLK or negedge ARST_N)
		if (!ARST_N)
			quiet_reg <= 8'h00;
		else
			quiet_reg <= quiet_next;
	////////////////////////////////////////////////////////////////////////
	// margin of a few cycles for the pin synchronisers
	oe_idle_a: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
		$changed(PORT_EN_OE) |-> quiet_reg >= 8'h50)
		else $error("enable pin moved while bus busy");
	pin_open_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		PORT_EN_O == 4'h0) else $error("enable pin driven high");
	done_pulse_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		EN_DONE |=> !EN_DONE) else $error("done longer than one cycle");
	take_ready_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		EN_REQ_VALID && EN_REQ_READY |=> !EN_REQ_READY [*8])
		else $error("ready stayed high after request");
	done_busy_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		EN_DONE |-> !EN_REQ_READY) else $error("ready high with done");
	state_hold_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		$changed(EN_STATE) |-> EN_DONE) else $error("state moved without done");
	state_pins_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		EN_DONE |-> EN_STATE == PORT_EN_I) else $error("state not pin level");
	oe_quiet_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		$changed(PORT_EN_OE) |-> !EN_REQ_READY)
		else $error("enable pin moved with no request");
	reset_vals_a: assert property (@(posedge CLK)
		!ARST_N |-> PORT_EN_OE == 4'h0 && !EN_REQ_READY && !EN_DONE)
		else $error("bad value in reset");
	idle_low_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		!DATA_FIRST_LOW_LINE_I [*4] |-> ##[0:20] !BUS_IDLE)
		else $error("idle flag missed low line");
	done_c: cover property (@(posedge CLK) EN_DONE);
	take_c: cover property (@(posedge CLK) EN_REQ_VALID && EN_REQ_READY);
	oe_c: cover property (@(posedge LINK_CLK) $changed(PORT_EN_OE));
endmodule // hub_enable_chk

bind hub_enable_ctrl hub_enable_chk chk (.CLK(CLK), .ARST_N(ARST_N),
	.LINK_CLK(LINK_CLK), .EN_REQ_VALID(EN_REQ_VALID),
	.EN_REQ_READY(EN_REQ_READY), .EN_DONE(EN_DONE), .EN_STATE(EN_STATE),
	.BUS_IDLE(BUS_IDLE), .PORT_EN_I(PORT_EN_I), .PORT_EN_O(PORT_EN_O),
	.PORT_EN_OE(PORT_EN_OE), .DATA_FIRST_LOW_LINE_I(DATA_FIRST_LOW_LINE_I),
	.DATA_HELD_LOW_LINE_I(DATA_HELD_LOW_LINE_I),
	.CLOCK_FIRST_LOW_LINE_I(CLOCK_FIRST_LOW_LINE_I),
	.CLOCK_HELD_LOW_LINE_I(CLOCK_HELD_LOW_LINE_I));

/* File: hub_model.sv */
`timescale 1ns/1ps
module hub_model
(
	input  wire logic [3:0] en_pin,
	input  wire logic [4:0] ext_sda,
	input  wire logic [4:0] ext_scl,
	output      logic [4:0] sda_line,
	output      logic [4:0] scl_line,
	output      logic       data_first,
	output      logic       data_held,
	output      logic       clock_first,
	output      logic       clock_held
);
	logic [4:0] act;
	logic [4:0] sda_hard;
	logic [4:0] scl_hard;
	// zero-delay release: staging collapses into one step
	assign act = {en_pin, 1'b1};
	assign sda_hard = ext_sda & act;
	assign scl_hard = ext_scl & act;
	assign data_first = ~|sda_hard;
	assign data_held = ~|sda_hard;
	assign clock_first = ~|scl_hard;
	assign clock_held = ~|scl_hard;
	assign sda_line = ~(ext_sda | (act & {5{~data_first}}));
	assign scl_line = ~(ext_scl | (act & {5{~clock_first}}));
endmodule // hub_model

/* File: test_five_port_i2c_hub_repeater.sv */
`timescale 1ns/1ps
module test_five_port_i2c_hub_repeater;
	logic       clk, arst_n, link_clk, req_valid, ready, done, bus_idle;
	logic [3:0] req_mask, state, en_o, en_oe, xpull, pin;
	logic [4:0] ext_sda, ext_scl, sda, scl;
	logic       dfl, dhl, cfl, chl;
	int         failures, tests_run;
	// pull-up on each enable pin, wired with the bench's extra driver
	assign pin = ~((en_oe & ~en_o) | xpull);
	hub_enable_ctrl uut (.CLK(clk), .ARST_N(arst_n), .LINK_CLK(link_clk),
		.EN_REQ_VALID(req_valid), .EN_REQ_MASK(req_mask),
		.EN_REQ_READY(ready), .EN_DONE(done), .EN_STATE(state),
		.BUS_IDLE(bus_idle), .PORT_EN_I(pin), .PORT_EN_O(en_o),
		.PORT_EN_OE(en_oe), .SDA_I(sda), .SCL_I(scl),
		.DATA_FIRST_LOW_LINE_I(dfl), .DATA_HELD_LOW_LINE_I(dhl),
		.CLOCK_FIRST_LOW_LINE_I(cfl), .CLOCK_HELD_LOW_LINE_I(chl));
	hub_model hub (.en_pin(pin), .ext_sda(ext_sda), .ext_scl(ext_scl),
		.sda_line(sda), .scl_line(scl), .data_first(dfl), .data_held(dhl),
		.clock_first(cfl), .clock_held(chl));
	always #5 clk = ~clk;
	initial #3.3 forever #6 link_clk = ~link_clk;
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic send(input logic [3:0] m);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 500)
		begin
			@(posedge clk);
			n++;
		end
		check({7'h00, ready}, 8'h01);
		#1;
		req_valid = 1'b1;
		req_mask = m;
		@(posedge clk);
		#1;
		req_valid = 1'b0;
	endtask
	// no upper bound on the answer, so only a generous limit
	task automatic wait_done(input logic [3:0] exp);
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (done !== 1'b1 && n < 5000);
		check({7'h00, done}, 8'h01);
		check({4'h0, state}, {4'h0, exp});
	endtask
	task automatic apply(input logic [3:0] m, input logic [3:0] exp);
		send(m);
		wait_done(exp);
		check({4'h0, en_oe}, {4'h0, ~m});
		check({4'h0, en_o}, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_masks();
		logic [3:0] tab[4] = '{4'hA, 4'h5, 4'hF, 4'h0};
		foreach (tab[i])
			apply(tab[i], tab[i]);
		#1 ext_sda = 5'h02;
		repeat (30) @(posedge clk);
		check({7'h00, bus_idle}, 8'h01);
		#1 ext_sda = 5'h03;
		repeat (30) @(posedge clk);
		check({7'h00, bus_idle}, 8'h00);
		check({3'h0, sda}, 8'h1C);
		#1 ext_sda = 5'h00;
		$display("test masks done");
	endtask
	task automatic t_busy();
		ext_scl = 5'h01;
		send(4'hF);
		repeat (300) @(posedge clk);
		check({4'h0, en_oe}, 8'h0F);
		check({7'h00, ready}, 8'h00);
		#1 ext_scl = 5'h00;
		wait_done(4'hF);
		check({4'h0, en_oe}, 8'h00);
		$display("test busy done");
	endtask
	task automatic t_refused();
		send(4'h3);
		@(posedge clk);
		#1 req_valid = 1'b1;
		req_mask = 4'hC;
		repeat (5) @(posedge clk);
		check({7'h00, ready}, 8'h00);
		#1 req_valid = 1'b0;
		wait_done(4'h3);
		check({4'h0, en_oe}, 8'h0C);
		$display("test refused done");
	endtask
	task automatic t_wired();
		#1 xpull = 4'h4;
		apply(4'hF, 4'hB);
		#1 xpull = 4'h0;
		$display("test wired done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		link_clk = 1'b0;
		arst_n = 1'b1;
		req_valid = 1'b0;
		req_mask = 4'h0;
		xpull = 4'h0;
		ext_sda = 5'h00;
		ext_scl = 5'h00;
		failures = 0;
		tests_run = 0;
		#1 arst_n = 1'b0;
		repeat (5) @(posedge clk);
		check({4'h0, state}, 8'h0F);
		check({4'h0, en_oe}, 8'h00);
		#1 arst_n = 1'b1;
		repeat (10) @(posedge clk);
		t_masks();
		t_busy();
		t_refused();
		t_wired();
		final_report();
	end
	initial
	begin
		#100000;
		failures++;
		final_report();
	end
endmodule // test_five_port_i2c_hub_repeater
